// ==== gw_params.svh ====
// timing counts, register offsets, field positions and reset values
`ifndef GW_PARAMS_SVH
`define GW_PARAMS_SVH

`define GW_CLK_HZ        40000000
`define GW_BAUD          9600
`define GW_GAP_MS        20
`define GW_GAP_CYC       ((`GW_CLK_HZ / 1000) * `GW_GAP_MS)
`define GW_BAUD_DIV      (`GW_CLK_HZ / `GW_BAUD)
`define GW_DATA_BYTES    8
`define GW_START_WAIT    2'h3

`define GW_OFF_OUT_CTRL  8'h00
`define GW_OFF_OUT_LO    8'h04
`define GW_OFF_OUT_HI    8'h08
`define GW_OFF_IN_CTRL   8'h0C
`define GW_OFF_IN_LO     8'h10
`define GW_OFF_IN_HI     8'h14
`define GW_OFF_STATUS    8'h18

`define GW_BIT_CMD       0
`define GW_BIT_BCAST     1
`define GW_BIT_TOGGLE    7
`define GW_BIT_GATE      1
`define GW_BIT_BUSY      4
`define GW_BIT_LOSS      5

`define GW_RST_CTRL      16'h0000
`define GW_RST_BYTE      8'h00

`define GW_DEV_HANDHELD  4'h1
`define GW_DEV_NETWORK   4'h2

`define GW_STX           8'h02
`define GW_CR            8'h0D
`define GW_LF            8'h0A
`define GW_NUL           8'h00
`define GW_SPACE         8'h20
`define GW_CH_ZERO       8'h30
`define GW_CH_BCAST      8'h42
`define GW_CH_GATE_ON    8'h2B
`define GW_CH_GATE_OFF   8'h2D
`define GW_CH_VERSION    8'h76
`define GW_CH_DEV2       8'h72
`define GW_CH_DEV3       8'h48

`endif

// ==== gw_pkg.sv ====
// types shared by the gateway modules
package gw_pkg;
  typedef logic [7:0] byte_type;
  typedef enum {TX_IDLE, TX_STX, TX_BCAST, TX_BODY, TX_CMD, TX_CR, TX_LF}
    tx_state_type;
endpackage

// ==== gw_uart_tx.sv ====
// 8n1 serial transmitter, one start and one stop bit
`timescale 1ns/10ps
module gw_uart_tx
  import gw_pkg::*;
#(
  parameter int DIV = 4166
)
(
  // clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // byte handshake
  input  wire byte_type data,
  input  wire logic     valid,
  output logic          ready,
  // line
  output logic          txd
);
  localparam int W = $clog2(DIV);

  logic         busy, next_busy;
  logic [W-1:0] cnt, next_cnt;
  logic [3:0]   bitn, next_bitn;
  logic [9:0]   sh, next_sh;
  logic         next_txd;

  assign ready = !busy;

  always_comb
  begin
    next_busy = busy;
    next_cnt  = cnt;
    next_bitn = bitn;
    next_sh   = sh;
    next_txd  = txd;
    if (!busy && valid)
    begin
      next_busy = 1'b1;
      next_sh   = {1'b1, data, 1'b0};
      next_cnt  = '0;
      next_bitn = 4'h0;
      next_txd  = 1'b0;
    end
    else if (busy)
    begin
      if (cnt == W'(DIV - 1))
      begin
        next_cnt = '0;
        if (bitn == 4'h9)
        begin
          next_busy = 1'b0;
          next_txd  = 1'b1;
        end
        else
        begin
          next_bitn = bitn + 4'h1;
          next_sh   = {1'b1, sh[9:1]};
          next_txd  = sh[1];
        end
      end
      else
        next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      cnt  <= '0;
      bitn <= 4'h0;
      sh   <= 10'h3ff;
      txd  <= 1'b1;
    end
    else
    begin
      busy <= next_busy;
      cnt  <= next_cnt;
      bitn <= next_bitn;
      sh   <= next_sh;
      txd  <= next_txd;
    end
  end
endmodule

// ==== gw_uart_rx.sv ====
// 8n1 serial receiver with input synchroniser, mid-bit sampling
`timescale 1ns/10ps
`include "gw_params.svh"
module gw_uart_rx
  import gw_pkg::*;
#(
  parameter int DIV = 4166
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // line
  input  wire logic rxd,
  // received byte, valid for one cycle
  output byte_type  data,
  output logic      valid
);
  localparam int W = $clog2(DIV);

  logic         s1, s2;
  logic         busy, next_busy;
  logic [W-1:0] cnt, next_cnt;
  logic [3:0]   bitn, next_bitn;
  byte_type     next_data;
  logic         next_valid;

  always_comb
  begin
    next_busy  = busy;
    next_cnt   = cnt;
    next_bitn  = bitn;
    next_data  = data;
    next_valid = 1'b0;
    if (!busy)
    begin
      if (!s2)
      begin
        next_busy = 1'b1;
        next_cnt  = W'(DIV / 2);
        next_bitn = 4'h0;
      end
    end
    else if (cnt == '0)
    begin
      next_cnt = W'(DIV - 1);
      next_bitn = bitn + 4'h1;
      // a start bit that has gone high again was a glitch
      if (bitn == 4'h0 && s2)
        next_busy = 1'b0;
      else if (bitn == 4'h9)
      begin
        next_busy  = 1'b0;
        next_valid = s2;
      end
      else if (bitn != 4'h0)
        next_data = {s2, data[7:1]};
    end
    else
      next_cnt = cnt - W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      busy  <= 1'b0;
      cnt   <= '0;
      bitn  <= 4'h0;
      data  <= `GW_RST_BYTE;
      valid <= 1'b0;
    end
    else
    begin
      s1    <= rxd;
      s2    <= s1;
      busy  <= next_busy;
      cnt   <= next_cnt;
      bitn  <= next_bitn;
      data  <= next_data;
      valid <= next_valid;
    end
  end
endmodule

// ==== fieldbus_serial_gateway.sv ====
// gateway between a controller process image on apb and a serial reader
`include "gw_params.svh"
`timescale 1ns/10ps
module fieldbus_serial_gateway
  import gw_pkg::*;
#(
  parameter int BAUD_DIV   = `GW_BAUD_DIV,
  parameter int GAP_CYCLES = `GW_GAP_CYC
)
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reader serial line and device selection switch
  output logic             serial_txd,
  input  wire logic        serial_rxd,
  input  wire logic [3:0]  device_select
);
  localparam int NB = `GW_DATA_BYTES;
  localparam int GW = $clog2(GAP_CYCLES + 1);

  // apb and process image state
  logic [15:0]  out_ctrl, next_out_ctrl;
  byte_type     out_data [NB];
  byte_type     next_out_data [NB];
  logic         last_toggle, next_last_toggle;
  logic         loss, next_loss;
  logic [31:0]  next_prdata;
  logic         next_pslverr;
  logic [3:0]   dev_sync1, dev_sync2, dev_type, next_dev_type;
  logic [1:0]   start_cnt, next_start_cnt;
  logic         wr, set_send;
  logic [8:0]   set_cmd;
  // transmit state
  tx_state_type tx_state, next_tx_state;
  byte_type     snap [NB];
  byte_type     next_snap [NB];
  logic [3:0]   idx, next_idx;
  logic [3:0]   cmd_sel, next_cmd_sel;
  logic         is_cmd, next_is_cmd;
  logic         bcast, next_bcast;
  logic         pend_send, next_pend_send;
  logic [8:0]   cmd_pend, next_cmd_pend;
  byte_type     tx_byte;
  logic         tx_valid, tx_ready, tx_take;
  // receive state
  byte_type     rx_byte;
  logic         rx_valid;
  byte_type     rx_buf [NB];
  byte_type     next_rx_buf [NB];
  logic [3:0]   rx_cnt, next_rx_cnt;
  logic         rx_active, next_rx_active;
  logic         rx_stop, next_rx_stop;
  logic [GW-1:0] gap_cnt, next_gap_cnt;
  byte_type     in_data [NB];
  byte_type     next_in_data [NB];
  logic [7:0]   in_len, next_in_len;
  logic         in_toggle, next_in_toggle;
  logic         set_loss;

  function automatic byte_type cmd_char(input logic [3:0] i);
    case (i)
      4'h0:    cmd_char = `GW_CH_VERSION;
      4'h1:    cmd_char = `GW_CH_GATE_ON;
      4'h2:    cmd_char = `GW_CH_DEV2;
      4'h3:    cmd_char = `GW_CH_DEV3;
      4'h8:    cmd_char = `GW_CH_GATE_OFF;
      default: cmd_char = `GW_NUL;
    endcase
  endfunction

  function automatic logic [3:0] lowest(input logic [8:0] v);
    lowest = 4'h0;
    for (int i = 8; i >= 0; i--)
      if (v[i])
        lowest = 4'(i);
  endfunction

  function automatic logic [31:0] pack(input byte_type b0, input byte_type b1,
                                       input byte_type b2, input byte_type b3);
    pack = {b3, b2, b1, b0};
  endfunction

  // registers answer with no wait state
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;

  always_comb
  begin
    next_out_ctrl    = out_ctrl;
    next_out_data    = out_data;
    next_last_toggle = last_toggle;
    next_loss        = loss;
    next_prdata      = prdata;
    next_pslverr     = pslverr;
    next_dev_type    = dev_type;
    next_start_cnt   = start_cnt;
    set_send         = 1'b0;
    set_cmd          = 9'h000;
    // wait for the synchroniser to settle before catching the switch
    if (start_cnt != `GW_START_WAIT)
    begin
      next_start_cnt = start_cnt + 2'h1;
      next_dev_type  = dev_sync2;
    end
    if (psel && !penable)
    begin
      next_pslverr = 1'b0;
      case (paddr)
        `GW_OFF_OUT_CTRL: next_prdata = {16'h0000, out_ctrl};
        `GW_OFF_OUT_LO:   next_prdata = pack(out_data[0], out_data[1],
                                             out_data[2], out_data[3]);
        `GW_OFF_OUT_HI:   next_prdata = pack(out_data[4], out_data[5],
                                             out_data[6], out_data[7]);
        `GW_OFF_IN_CTRL:  next_prdata = {16'h0000, in_len, in_toggle,
                                         7'h00};
        `GW_OFF_IN_LO:    next_prdata = pack(in_data[0], in_data[1],
                                             in_data[2], in_data[3]);
        `GW_OFF_IN_HI:    next_prdata = pack(in_data[4], in_data[5],
                                             in_data[6], in_data[7]);
        `GW_OFF_STATUS:   next_prdata = {26'h000_0000, loss,
                                         tx_state != TX_IDLE, dev_type};
        default:
        begin
          next_prdata  = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr)
    begin
      case (paddr)
        `GW_OFF_OUT_CTRL:
        begin
          next_out_ctrl    = pwdata[15:0];
          next_last_toggle = pwdata[`GW_BIT_TOGGLE];
          // the flag is tracked in command mode too, so leaving it later
          // does not fire a stale send
          if (!pwdata[`GW_BIT_CMD] &&
              pwdata[`GW_BIT_TOGGLE] != last_toggle)
            set_send = 1'b1;
        end
        `GW_OFF_OUT_LO:
        begin
          for (int i = 0; i < 4; i++)
            next_out_data[i] = pwdata[8*i +: 8];
          if (out_ctrl[`GW_BIT_CMD] && dev_type != `GW_DEV_HANDHELD)
            set_cmd = {out_data[0][`GW_BIT_GATE] &
                       !pwdata[`GW_BIT_GATE],
                       pwdata[7:0] & ~out_data[0]};
        end
        `GW_OFF_OUT_HI:
          for (int i = 0; i < 4; i++)
            next_out_data[i + 4] = pwdata[8*i +: 8];
        `GW_OFF_STATUS:
          if (pwdata[`GW_BIT_LOSS])
            next_loss = 1'b0;
        default: ;
      endcase
    end
    if (set_loss)
      next_loss = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_ctrl    <= `GW_RST_CTRL;
      out_data    <= '{default: `GW_RST_BYTE};
      last_toggle <= 1'b0;
      loss        <= 1'b0;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      dev_sync1   <= 4'h0;
      dev_sync2   <= 4'h0;
      dev_type    <= 4'h0;
      start_cnt   <= 2'h0;
    end
    else
    begin
      out_ctrl    <= next_out_ctrl;
      out_data    <= next_out_data;
      last_toggle <= next_last_toggle;
      loss        <= next_loss;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
      dev_sync1   <= device_select;
      dev_sync2   <= dev_sync1;
      dev_type    <= next_dev_type;
      start_cnt   <= next_start_cnt;
    end
  end

  // transmit sequencer: one framed telegram at a time
  always_comb
  begin
    case (tx_state)
      TX_STX:   tx_byte = `GW_STX;
      TX_BCAST: tx_byte = (idx == 4'h2) ? `GW_CH_BCAST : `GW_CH_ZERO;
      TX_BODY:  tx_byte = snap[idx[2:0]];
      TX_CMD:   tx_byte = cmd_char(cmd_sel);
      TX_CR:    tx_byte = `GW_CR;
      TX_LF:    tx_byte = `GW_LF;
      default:  tx_byte = `GW_NUL;
    endcase
  end

  assign tx_valid = tx_state != TX_IDLE;
  assign tx_take  = tx_valid && tx_ready;

  always_comb
  begin
    next_tx_state  = tx_state;
    next_snap      = snap;
    next_idx       = idx;
    next_cmd_sel   = cmd_sel;
    next_is_cmd    = is_cmd;
    next_bcast     = bcast;
    next_pend_send = pend_send;
    next_cmd_pend  = cmd_pend;
    case (tx_state)
      TX_IDLE:
        if (pend_send && !out_ctrl[`GW_BIT_CMD])
        begin
          next_pend_send = 1'b0;
          next_snap      = out_data;
          next_is_cmd    = 1'b0;
          next_bcast     = out_ctrl[`GW_BIT_BCAST] &&
                           dev_type == `GW_DEV_NETWORK;
          next_tx_state  = TX_STX;
        end
        else if (cmd_pend != 9'h000)
        begin
          next_cmd_sel  = lowest(cmd_pend);
          next_cmd_pend = cmd_pend & ~(9'h001 << lowest(cmd_pend));
          next_is_cmd   = 1'b1;
          next_tx_state = TX_STX;
        end
        else if (pend_send)
          next_pend_send = 1'b0;
      TX_STX:
        if (tx_take)
        begin
          next_idx = 4'h0;
          if (is_cmd)
            next_tx_state = TX_CMD;
          else if (bcast)
            next_tx_state = TX_BCAST;
          else
            next_tx_state = (snap[0] == `GW_NUL) ? TX_CR : TX_BODY;
        end
      TX_BCAST:
        if (tx_take)
        begin
          next_idx = idx + 4'h1;
          if (idx == 4'h2)
          begin
            next_idx      = 4'h0;
            next_tx_state = (snap[0] == `GW_NUL) ? TX_CR : TX_BODY;
          end
        end
      TX_BODY:
        if (tx_take)
        begin
          // zero bytes are unused padding of the output image
          if (idx == 4'(NB - 1) || snap[idx[2:0] + 3'h1] == `GW_NUL)
            next_tx_state = TX_CR;
          else
            next_idx = idx + 4'h1;
        end
      TX_CMD:
        if (tx_take)
          next_tx_state = TX_CR;
      TX_CR:
        if (tx_take)
          next_tx_state = TX_LF;
      TX_LF:
        if (tx_take)
          next_tx_state = TX_IDLE;
      default: next_tx_state = TX_IDLE;
    endcase
    // a request arriving while the old one is taken is kept
    if (set_send)
      next_pend_send = 1'b1;
    next_cmd_pend = next_cmd_pend | set_cmd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state  <= TX_IDLE;
      snap      <= '{default: `GW_RST_BYTE};
      idx       <= 4'h0;
      cmd_sel   <= 4'h0;
      is_cmd    <= 1'b0;
      bcast     <= 1'b0;
      pend_send <= 1'b0;
      cmd_pend  <= 9'h000;
    end
    else
    begin
      tx_state  <= next_tx_state;
      snap      <= next_snap;
      idx       <= next_idx;
      cmd_sel   <= next_cmd_sel;
      is_cmd    <= next_is_cmd;
      bcast     <= next_bcast;
      pend_send <= next_pend_send;
      cmd_pend  <= next_cmd_pend;
    end
  end

  // receive path runs in every mode, command answers included
  always_comb
  begin
    logic publish;
    publish        = 1'b0;
    set_loss       = 1'b0;
    next_rx_buf    = rx_buf;
    next_rx_cnt    = rx_cnt;
    next_rx_active = rx_active;
    next_rx_stop   = rx_stop;
    next_gap_cnt   = gap_cnt;
    next_in_data   = in_data;
    next_in_len    = in_len;
    next_in_toggle = in_toggle;
    if (rx_valid)
    begin
      next_gap_cnt   = '0;
      next_rx_active = 1'b1;
      if (rx_byte == `GW_STX)
      begin
        next_rx_cnt  = 4'h0;
        next_rx_stop = 1'b0;
      end
      else if (rx_byte == `GW_CR || rx_byte == `GW_LF)
        publish = 1'b1;
      else if (rx_byte == `GW_NUL)
        next_rx_stop = 1'b1;
      else if (rx_byte < `GW_SPACE)
        next_rx_stop = rx_stop;
      else if (!rx_stop)
      begin
        if (rx_cnt < 4'(NB))
        begin
          next_rx_buf[rx_cnt[2:0]] = rx_byte;
          next_rx_cnt = rx_cnt + 4'h1;
        end
        else
          set_loss = 1'b1;
      end
    end
    else if (rx_active)
    begin
      if (gap_cnt == GW'(GAP_CYCLES))
        publish = 1'b1;
      else
        next_gap_cnt = gap_cnt + GW'(1);
    end
    if (publish)
    begin
      next_rx_active = 1'b0;
      next_rx_stop   = 1'b0;
      next_rx_cnt    = 4'h0;
      next_gap_cnt   = '0;
      if (rx_cnt != 4'h0)
      begin
        for (int i = 0; i < NB; i++)
          next_in_data[i] = (4'(i) < rx_cnt) ? rx_buf[i] : `GW_NUL;
        next_in_len    = {4'h0, rx_cnt};
        next_in_toggle = !in_toggle;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_buf    <= '{default: `GW_RST_BYTE};
      rx_cnt    <= 4'h0;
      rx_active <= 1'b0;
      rx_stop   <= 1'b0;
      gap_cnt   <= '0;
      in_data   <= '{default: `GW_RST_BYTE};
      in_len    <= `GW_RST_BYTE;
      in_toggle <= 1'b0;
    end
    else
    begin
      rx_buf    <= next_rx_buf;
      rx_cnt    <= next_rx_cnt;
      rx_active <= next_rx_active;
      rx_stop   <= next_rx_stop;
      gap_cnt   <= next_gap_cnt;
      in_data   <= next_in_data;
      in_len    <= next_in_len;
      in_toggle <= next_in_toggle;
    end
  end

  gw_uart_tx #(.DIV(BAUD_DIV)) u_tx
  (
    .pclk    (pclk),
    .presetn (presetn),
    .data    (tx_byte),
    .valid   (tx_valid),
    .ready   (tx_ready),
    .txd     (serial_txd)
  );

  gw_uart_rx #(.DIV(BAUD_DIV)) u_rx
  (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd     (serial_rxd),
    .data    (rx_byte),
    .valid   (rx_valid)
  );
endmodule

// ==== gw_chk.sv ====
// assertions on the gateway's apb and serial ports
`timescale 1ns/10ps
module gw_chk
#(
  parameter int BAUD_DIV = 8
)
(
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // reader side
  input wire logic        serial_txd
);
  logic       last_nd;
  logic       next_last_nd;
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  logic       acc;
  logic       bad;
  logic       ctrl_wr;
  logic       idle;
  logic       send_req;

  assign acc = psel && penable;
  assign bad = paddr > 8'h18 || paddr[1:0] != 2'h0;
  assign ctrl_wr = acc && pwrite && paddr == 8'h00;
  // a high run longer than one byte means the sender has no telegram going
  assign idle = int'(quiet) >= 10 * BAUD_DIV;
  assign send_req = ctrl_wr && !pwdata[0] && pwdata[7] != last_nd && idle;

  always_comb
  begin
    next_last_nd = ctrl_wr ? pwdata[7] : last_nd;
    next_quiet = !serial_txd ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_nd <= 1'b0;
      quiet <= 8'h00;
    end
    else
    begin
      last_nd <= next_last_nd;
      quiet <= next_quiet;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence start_bit;
    serial_txd ##[1:2] !serial_txd;
  endsequence

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && bad |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_read_stands: assert property (acc ##1 !psel |-> $stable(prdata))
    else $error("read data moved after access");
  a_send_start: assert property (send_req |-> ##1 start_bit)
    else $error("telegram did not start");
  a_cmd_silent: assert property (
    ctrl_wr && pwdata[0] && idle |=> serial_txd [*8])
    else $error("line moved in command mode");
  a_bit_width: assert property ($fell(serial_txd) |-> !serial_txd [*8])
    else $error("serial bit too short");
  a_idle_high: assert property ($rose(presetn) |-> serial_txd)
    else $error("line not idle after reset");
endmodule

bind fieldbus_serial_gateway gw_chk #(.BAUD_DIV(BAUD_DIV)) gw_chk_i
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_txd(serial_txd)
);

// ==== gw_reader_model.sv ====
// serial reader model: decodes gateway telegrams, sends reader data
`timescale 1ns/10ps
module gw_reader_model
#(
  parameter int DIV = 8,
  parameter int GAP = 212
)
(
  // bench clock
  input wire logic pclk,
  // serial lines
  input wire logic txd,
  output logic     rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rxd = 1'b1;

  // mid-bit sampling, lsb first, one start and one stop bit
  always
  begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge pclk);
      sh[i] = txd;
    end
    repeat (DIV) @(posedge pclk);
    got.push_back(sh);
  end

  // line idles high after the bytes, long enough to end a telegram
  task automatic send(input logic [7:0] s[$]);
    foreach (s[k])
      for (int i = 0; i < 10; i++)
      begin
        rxd <= i == 0 ? 1'b0 : (i == 9 ? 1'b1 : s[k][i - 1]);
        repeat (DIV) @(posedge pclk);
      end
    repeat (GAP) @(posedge pclk);
  endtask
endmodule

// ==== tb_fieldbus_serial_gateway.sv ====
// self-checking bench: apb accesses against a serial reader model
`timescale 1ns/10ps
module tb_fieldbus_serial_gateway;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_txd;
  logic        serial_rxd;
  logic [3:0]  device_select = 4'h2;
  logic [31:0] r;
  logic        e;
  logic [7:0]  exp_tx[$];
  logic [7:0]  cmds[4] = '{8'h76, 8'h2b, 8'h72, 8'h48};
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  fieldbus_serial_gateway #(.BAUD_DIV(8), .GAP_CYCLES(200))
    fieldbus_serial_gateway_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_txd(serial_txd),
    .serial_rxd(serial_rxd), .device_select(device_select)
  );

  gw_reader_model gw_reader_model_i
  (
    .pclk(pclk), .txd(serial_txd), .rxd(serial_rxd)
  );

  always #12.5 pclk = ~pclk;

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, want);
  endtask

  // waits for the expected bytes, then compares them in order
  task automatic tx_chk();
    int t;
    t = 0;
    while (gw_reader_model_i.got.size() < exp_tx.size() && t < 4000)
    begin
      @(posedge pclk);
      t++;
    end
    while (exp_tx.size() > 0 && gw_reader_model_i.got.size() > 0)
      chk(gw_reader_model_i.got.pop_front(), exp_tx.pop_front());
    chk(exp_tx.size() + gw_reader_model_i.got.size(), 0);
    exp_tx.delete();
    gw_reader_model_i.got.delete();
  endtask

  task automatic frame(input logic [7:0] c);
    exp_tx.push_back(8'h02);
    exp_tx.push_back(c);
    exp_tx.push_back(8'h0d);
    exp_tx.push_back(8'h0a);
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h18, 32'h0000_0002);
    rd(8'h1c, 32'h0000_0000);
    chk(e, 1'b1);
    $display("test reset done");
    repeat (100) @(posedge pclk);
    apb(1'b1, 8'h04, 32'h0000_4241);
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0082);
    exp_tx = {8'h02, 8'h30, 8'h30, 8'h42, 8'h41, 8'h42, 8'h0d, 8'h0a};
    tx_chk();
    repeat (100) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0000_0082);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    tx_chk();
    $display("test send done");
    apb(1'b1, 8'h04, 32'h0000_000f);
    foreach (cmds[i])
      frame(cmds[i]);
    tx_chk();
    apb(1'b1, 8'h04, 32'h0000_0000);
    frame(8'h2d);
    tx_chk();
    $display("test command done");
    gw_reader_model_i.send('{8'h02, 8'h41, 8'h01, 8'h42, 8'h0d, 8'h0a});
    rd(8'h0c, 32'h0000_0280);
    rd(8'h10, 32'h0000_4241);
    rd(8'h14, 32'h0000_0000);
    gw_reader_model_i.send('{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
                             8'h47, 8'h48, 8'h49, 8'h4a});
    rd(8'h0c, 32'h0000_0800);
    rd(8'h10, 32'h4443_4241);
    rd(8'h14, 32'h4847_4645);
    rd(8'h18, 32'h0000_0022);
    apb(1'b1, 8'h18, 32'h0000_0020);
    rd(8'h18, 32'h0000_0002);
    gw_reader_model_i.send('{8'h43, 8'h00, 8'h44});
    rd(8'h0c, 32'h0000_0180);
    rd(8'h10, 32'h0000_0043);
    $display("test receive done");
    // second reset with a hand-held scanner selected
    presetn <= 1'b0;
    device_select <= 4'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h18, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_000f);
    repeat (200) @(posedge pclk);
    tx_chk();
    apb(1'b1, 8'h00, 32'h0000_0082);
    frame(8'h0f);
    tx_chk();
    $display("test handheld done");
    finish_test();
  end
endmodule
